// ### logic/hs_output_ctrl_diag_regs.sv
// High-side output control and diagnostic register bank behind a 24-bit serial port.
//
// Function
// - Overcurrent sets flag, output off, summary flag.
// - Recovery bit re-enables output after delay.
// - Rate bit picks slow/fast, not bulb output.
// - Outputs gated by PWM one, two, internal.
// - Selected output on only while PWM high.
// - Voltage recovery automatic unless disabled; host clears.
// - Nonzero sense field turns shared pin output.
// - Sense multiplexer covers only high-side stages.
// - Write frame returns status then previous contents.
// - Mode clear: standby, registers cleared, outputs off.
`timescale 1ns/1ps
`default_nettype none

module hs_output_ctrl_diag_regs
   import hs_regs_pkg::*;
#(
   parameter int unsigned REC_SLOW_CYC = REC_SLOW_US * MCLK_MHZ,
   parameter int unsigned REC_BULB_CYC = REC_BULB_US * MCLK_MHZ
) (
   // System clock and reset.
   input  wire logic             mclk,
   input  wire logic             resetn,
   // Serial port, the link side runs on its own clock.
   input  wire logic             sclk,
   input  wire logic             cs_n,
   input  wire logic             si,
   output logic                  so_o,
   output logic                  so_oe,
   // Analog fault detectors, one bit per output four to seven.
   input  wire logic [3:0]       oc_det,
   input  wire logic [3:0]       uld_det,
   input  wire logic             vs_ov_det,
   input  wire logic             vs_uv_det,
   input  wire logic             bulb_mode,
   // PWM sources.
   input  wire logic             external_pwm_input_one,
   input  wire logic             shared_sense_pwm_pin_i,
   input  wire logic [2:0]       internal_pwm_generator,
   // Output stage and sense controls.
   output logic [3:0]            hs_gate,
   output logic [3:0]            sense_hs_onehot,
   output logic                  shared_sense_pwm_pin_oe,
   output logic                  standby
);

   // ------------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------------

   // Register read decode; unmapped addresses answer zero.
   function automatic logic [15:0] rd_word(input logic [5:0]  a,
                                           input logic        m,
                                           input logic [15:0] c1,
                                           input logic [15:0] c3,
                                           input logic [15:0] p56,
                                           input logic [15:0] s2);
      logic [15:0] w;
      w = REG_RESET;
      case (a)
         ADDR_CTRL0: w[CTRL0_MODE] = m;
         ADDR_CTRL1: w = c1;
         ADDR_CTRL3: w = c3;
         ADDR_PWM56: w = p56;
         ADDR_STAT2: w = s2;
         default:    w = REG_RESET;
      endcase
      return w;
   endfunction : rd_word

   // Masked write keeps unassigned positions at zero.
   function automatic logic [15:0] wr_mask(input logic [15:0] d, input logic [15:0] m);
      return d & m;
   endfunction : wr_mask

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic              spi_rst;          // Frame reset of the link logic.
   logic [4:0]        bit_cnt_q;        // Bits received in this frame.
   logic [23:0]       rx_q;             // Incoming shift register.
   logic [5:0]        addr_q;           // Address caught after the command byte.
   logic              so_q;             // Outgoing bit, changed on falling edges.
   logic [23:0]       frame_q;          // Last complete frame.
   logic              done_tgl_q;       // Toggles once per complete frame.
   logic [4:0]        tx_idx;           // Bit index of the answer being shifted.
   logic [15:0]       tx_data;          // Answer word from the snapshot.

   logic [14:0]       pin_s1_q;         // First synchroniser stage.
   logic [14:0]       pin_s2_q;         // Second synchroniser stage.
   logic              tgl_s3_q;         // Delayed toggle for edge detection.
   logic              cs_n_s, tgl_s, ov_s, uv_s, bulb_s, external_pwm_input_one_s, external_pwm_input_two_s;
   logic [3:0]        oc_s, uld_s;

   logic              frame_stb;        // One mclk pulse per received frame.
   logic [5:0]        cmd_addr;
   logic              wr_stb, clr_stb;

   logic              mode_q;
   logic [15:0]       ctrl1_q, ctrl3_q, pwm56_q;
   logic [3:0]        oc_flag_q, uld_flag_q, off_q;
   logic              ov_flag_q, uv_flag_q, uovoc_q;
   logic [REC_W-1:0]  rec_cnt_q [NUM_HS];
   logic [15:0]       stat2_w;
   logic              fault_w, supply_block;
   logic [3:0]        hs_en, ocr_en, pwm_ok, hs_gate_d;
   logic [3:0]        sense_sel;

   logic              snap_mode_q;
   logic [7:0]        snap_gs_q;
   logic [15:0]       snap_c1_q, snap_c3_q, snap_p56_q, snap_s2_q;

   // ------------------------------------------------------------------
   // Link side: shift in on rising edges
   // ------------------------------------------------------------------
   assign spi_rst = cs_n | ~resetn;

   // Counter and receive shift register restart with every frame.
   always_ff @(posedge sclk or posedge spi_rst) begin
      if (spi_rst) begin
         bit_cnt_q <= 5'd0;
         rx_q      <= 24'h000000;
         addr_q    <= 6'h00;
      end else begin
         rx_q <= {rx_q[22:0], si};
         if (bit_cnt_q != FRAME_BITS) begin
            bit_cnt_q <= bit_cnt_q + 5'd1;
         end
         if (bit_cnt_q == CMD_BITS - 5'd1) begin
            addr_q <= {rx_q[4:0], si};
         end
      end
   end

   // A complete frame is parked here and announced by a toggle; a
   // truncated frame never toggles and so is dropped whole.
   always_ff @(posedge sclk or negedge resetn) begin
      if (!resetn) begin
         frame_q    <= 24'h000000;
         done_tgl_q <= 1'b0;
      end else if (!cs_n && bit_cnt_q == FRAME_BITS - 5'd1) begin
         frame_q    <= {rx_q[22:0], si};
         done_tgl_q <= ~done_tgl_q;
      end
   end

   // Answer: status byte first, then the addressed word from the
   // snapshot, which still holds the value before this frame's write.
   assign tx_idx  = bit_cnt_q - CMD_BITS;
   assign tx_data = rd_word(addr_q, snap_mode_q, snap_c1_q, snap_c3_q, snap_p56_q, snap_s2_q);

   // Shift out on falling edges so the host samples a settled bit.
   always_ff @(negedge sclk or posedge spi_rst) begin
      if (spi_rst) begin
         so_q <= 1'b0;
      end else if (bit_cnt_q < CMD_BITS) begin
         so_q <= snap_gs_q[3'(CMD_BITS - 5'd1 - bit_cnt_q)];
      end else if (bit_cnt_q < FRAME_BITS) begin
         so_q <= tx_data[4'(5'd15 - tx_idx)];
      end else begin
         so_q <= 1'b0;
      end
   end

   // Before the first clock the status byte's top bit is already shown.
   assign so_o  = (bit_cnt_q == 5'd0) ? snap_gs_q[GS_FAULT] : so_q;
   assign so_oe = ~cs_n;

   // ------------------------------------------------------------------
   // Synchronisers into mclk
   // ------------------------------------------------------------------

   // Pins and the frame toggle pass two flip-flops before any use.
   // Stages reset to the idle levels: select high, toggle and detectors
   // low, so that no false frame strobe or fault follows reset.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pin_s1_q <= 15'h4000;
         pin_s2_q <= 15'h4000;
         tgl_s3_q <= 1'b0;
      end else begin
         pin_s1_q <= {cs_n, done_tgl_q, oc_det, uld_det, vs_ov_det, vs_uv_det,
                      bulb_mode, external_pwm_input_one, shared_sense_pwm_pin_i};
         pin_s2_q <= pin_s1_q;
         tgl_s3_q <= tgl_s;
      end
   end

   assign {cs_n_s, tgl_s, oc_s, uld_s, ov_s, uv_s, bulb_s, external_pwm_input_one_s, external_pwm_input_two_s} = pin_s2_q;

   // The toggle edge alone marks a frame; select rises a little later
   // through its own synchroniser, so gating with it could lose the write.
   assign frame_stb = tgl_s ^ tgl_s3_q;
   assign cmd_addr  = frame_q[21:16];
   assign wr_stb    = frame_stb & frame_q[16 + CMD_WRITE];
   assign clr_stb   = frame_stb & frame_q[16 + CMD_CLEAR] & (cmd_addr == ADDR_STAT2);

   // ------------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------------

   // In standby every control register is held cleared; only the mode
   // bit can be written then.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mode_q  <= 1'b0;
         ctrl1_q <= REG_RESET;
         ctrl3_q <= REG_RESET;
         pwm56_q <= REG_RESET;
      end else begin
         if (wr_stb && cmd_addr == ADDR_CTRL0) begin
            mode_q <= frame_q[CTRL0_MODE];
         end
         if (!mode_q) begin
            ctrl1_q <= REG_RESET;
            ctrl3_q <= REG_RESET;
            pwm56_q <= REG_RESET;
         end else if (wr_stb) begin
            if (cmd_addr == ADDR_CTRL1) ctrl1_q <= wr_mask(frame_q[15:0], CTRL1_MASK);
            if (cmd_addr == ADDR_CTRL3) ctrl3_q <= wr_mask(frame_q[15:0], CTRL3_MASK);
            if (cmd_addr == ADDR_PWM56) pwm56_q <= wr_mask(frame_q[15:0], PWM56_MASK);
         end
      end
   end

   // ------------------------------------------------------------------
   // Fault flags and overcurrent recovery
   // ------------------------------------------------------------------

   // Flags are sticky; a detector event in the clear cycle wins.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         oc_flag_q  <= 4'h0;
         uld_flag_q <= 4'h0;
         ov_flag_q  <= 1'b0;
         uv_flag_q  <= 1'b0;
         uovoc_q    <= 1'b0;
      end else if (!mode_q) begin
         oc_flag_q  <= 4'h0;
         uld_flag_q <= 4'h0;
         ov_flag_q  <= 1'b0;
         uv_flag_q  <= 1'b0;
         uovoc_q    <= 1'b0;
      end else begin
         oc_flag_q  <= (oc_flag_q & {4{~clr_stb}}) | oc_s;
         uld_flag_q <= (uld_flag_q & {4{~clr_stb}}) | uld_s;
         ov_flag_q  <= (ov_flag_q & ~clr_stb) | ov_s;
         uv_flag_q  <= (uv_flag_q & ~clr_stb) | uv_s;
         uovoc_q    <= (uovoc_q & ~clr_stb) | (|oc_s) | ov_s | uv_s;
      end
   end

   // Each output has a latch that holds it off after overcurrent and a
   // down-counter that times the automatic re-enable.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         off_q <= 4'h0;
         for (int i = 0; i < NUM_HS; i++) rec_cnt_q[i] <= '0;
      end else begin
         for (int i = 0; i < NUM_HS; i++) begin
            if (!mode_q) begin
               off_q[i]     <= 1'b0;
               rec_cnt_q[i] <= '0;
            end else if (oc_s[i]) begin
               off_q[i] <= 1'b1;
               if (i == 0 && bulb_s) begin
                  rec_cnt_q[i] <= REC_W'(REC_BULB_CYC - 1);
               end else if (ctrl3_q[CTRL3_RECOVERY_RATE_SELECT]) begin
                  rec_cnt_q[i] <= REC_W'(REC_FAST_CYC - 1);
               end else begin
                  rec_cnt_q[i] <= REC_W'(REC_SLOW_CYC - 1);
               end
            end else if (off_q[i] && ocr_en[i]) begin
               if (rec_cnt_q[i] == '0) off_q[i] <= 1'b0;
               else rec_cnt_q[i] <= rec_cnt_q[i] - REC_W'(1);
            end else if (off_q[i] && clr_stb) begin
               off_q[i] <= 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Output gating and sense selection
   // ------------------------------------------------------------------
   assign hs_en  = {ctrl1_q[CTRL1_HS4_HI] | ctrl1_q[CTRL1_HS4_LO], ctrl1_q[CTRL1_HS5],
                    ctrl1_q[CTRL1_HS5-1], ctrl1_q[CTRL1_HS5-2]};
   // Index 0 is output four, as for the detector vectors.
   assign ocr_en = {ctrl3_q[CTRL3_OCR_MSB-3], ctrl3_q[CTRL3_OCR_MSB-2],
                    ctrl3_q[CTRL3_OCR_MSB-1], ctrl3_q[CTRL3_OCR_MSB]};
   assign sense_sel = ctrl3_q[CTRL3_IS_MSB -: 4];

   // Without automatic recovery the outputs stay off until the flags go.
   assign supply_block = ctrl3_q[CTRL3_VOLTAGE_RECOVERY_DISABLE] ? (ov_flag_q | uv_flag_q)
                                              : (ov_s | uv_s);

   // Vector index 3 is output four; it and output six take input two,
   // five and seven take input one. The shared pin reads low as a PWM
   // source while it is driven as the sense output.
   always_comb begin
      logic src;
      logic ext_sel;
      logic int_sel;
      src = 1'b0;
      ext_sel = 1'b0;
      int_sel = 1'b0;
      pwm_ok = 4'h0;
      for (int i = 0; i < NUM_HS; i++) begin
         src     = (i % 2 == 0) ? (external_pwm_input_two_s & ~shared_sense_pwm_pin_oe)
                                : external_pwm_input_one_s;
         ext_sel = ctrl3_q[CTRL3_PWM_MSB - i];
         int_sel = (i < 3) ? pwm56_q[PWM56_INT_MSB - i] : 1'b0;
         if (int_sel) begin
            pwm_ok[3-i] = internal_pwm_generator[i];
         end else if (ext_sel) begin
            pwm_ok[3-i] = src;
         end else begin
            pwm_ok[3-i] = 1'b1;
         end
      end
   end

   assign hs_gate_d = {4{mode_q & ~supply_block}} & hs_en & pwm_ok
                      & ~{off_q[0], off_q[1], off_q[2], off_q[3]};

   // Output stage controls come from flip-flops.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         hs_gate                 <= 4'h0;
         sense_hs_onehot         <= 4'h0;
         shared_sense_pwm_pin_oe <= 1'b0;
      end else begin
         hs_gate                 <= hs_gate_d;
         shared_sense_pwm_pin_oe <= mode_q & (sense_sel != 4'h0);
         // Codes one to four pick outputs four to seven; the
         // half-bridges have no code at all.
         for (int k = 0; k < NUM_HS; k++) begin
            sense_hs_onehot[k] <= mode_q & (sense_sel == 4'(k + 1));
         end
      end
   end

   assign standby = ~mode_q;

   // ------------------------------------------------------------------
   // Status word and read snapshot
   // ------------------------------------------------------------------
   always_comb begin
      stat2_w = REG_RESET;
      for (int i = 0; i < NUM_HS; i++) begin
         stat2_w[STAT2_OC_MSB - 2*i]     = oc_flag_q[i];
         stat2_w[STAT2_OC_MSB - 2*i - 1] = uld_flag_q[i];
      end
      stat2_w[STAT2_SUPPLY_UNDERVOLTAGE_FLAG] = uv_flag_q;
      stat2_w[STAT2_VSOV] = ov_flag_q;
   end

   assign fault_w = (|stat2_w) | uovoc_q;

   // The snapshot is frozen while the select is low, so the link side
   // reads quasi-static words; this needs the host to wait a few mclk
   // cycles between select falling and the first clock edge.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         snap_mode_q <= 1'b0;
         snap_gs_q   <= 8'h00;
         snap_c1_q   <= REG_RESET;
         snap_c3_q   <= REG_RESET;
         snap_p56_q  <= REG_RESET;
         snap_s2_q   <= REG_RESET;
      end else if (cs_n_s && !frame_stb) begin
         snap_mode_q <= mode_q;
         snap_gs_q   <= 8'h00;
         snap_gs_q[GS_FAULT]  <= fault_w;
         snap_gs_q[GS_GLOBAL_FAULT_SUMMARY_FLAG] <= uovoc_q;
         snap_c1_q   <= ctrl1_q;
         snap_c3_q   <= ctrl3_q;
         snap_p56_q  <= pwm56_q;
         snap_s2_q   <= stat2_w;
      end
   end

endmodule : hs_output_ctrl_diag_regs

`default_nettype wire

// ### logic/hs_regs_pkg.sv
// Constants shared by the high-side output control and diagnostic register bank.
package hs_regs_pkg;

   // -----------------------------------------------------------------
   // Register addresses (six-bit address field of the command byte)
   // -----------------------------------------------------------------
   localparam logic [5:0]  ADDR_CTRL0  = 6'h00;  // Mode bit lives here.
   localparam logic [5:0]  ADDR_CTRL1  = 6'h01;  // High-side output enables.
   localparam logic [5:0]  ADDR_CTRL3  = 6'h03;  // Recovery, PWM routing, sense select.
   localparam logic [5:0]  ADDR_PWM56  = 6'h09;  // Internal PWM control for outputs 4 to 6.
   localparam logic [5:0]  ADDR_STAT0  = 6'h10;  // Bridge overcurrent status (reads zero here).
   localparam logic [5:0]  ADDR_STAT2  = 6'h12;  // High-side and supply status.

   // -----------------------------------------------------------------
   // Writable bit masks and reset value
   // -----------------------------------------------------------------
   localparam logic [15:0] REG_RESET   = 16'h0000;
   localparam logic [15:0] CTRL1_MASK  = 16'h3E00;
   localparam logic [15:0] CTRL3_MASK  = 16'h7BFF;
   localparam logic [15:0] PWM56_MASK  = 16'hFFFF;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int CTRL0_MODE     = 0;
   localparam int CTRL1_HS4_HI   = 13;
   localparam int CTRL1_HS4_LO   = 12;
   localparam int CTRL1_HS5      = 11;   // Outputs 5..7 follow downward.
   localparam int CTRL3_OCR_MSB  = 14;   // Output 4 at 14 down to output 7 at 11.
   localparam int CTRL3_PWM_MSB  = 9;    // Output 4 at 9 down to output 7 at 6.
   localparam int CTRL3_RECOVERY_RATE_SELECT     = 5;
   localparam int CTRL3_VOLTAGE_RECOVERY_DISABLE    = 4;
   localparam int CTRL3_IS_MSB   = 3;
   localparam int PWM56_INT_MSB  = 15;   // Internal select, output 4 at 15 to 6 at 13.
   localparam int STAT2_OC_MSB   = 13;   // Overcurrent 4 at 13, underload one below, step 2.
   localparam int STAT2_SUPPLY_UNDERVOLTAGE_FLAG     = 3;
   localparam int STAT2_VSOV     = 2;
   localparam int GS_FAULT       = 7;
   localparam int GS_GLOBAL_FAULT_SUMMARY_FLAG      = 6;

   // -----------------------------------------------------------------
   // Serial frame layout
   // -----------------------------------------------------------------
   localparam logic [4:0]  FRAME_BITS  = 5'd24;
   localparam logic [4:0]  CMD_BITS    = 5'd8;
   localparam int          CMD_WRITE   = 7;
   localparam int          CMD_CLEAR   = 6;
   localparam int          NUM_HS      = 4;

   // -----------------------------------------------------------------
   // Recovery timing
   // -----------------------------------------------------------------
   localparam int          MCLK_MHZ    = 25;
   localparam int          REC_SLOW_US = 1000;
   localparam int          REC_FAST_US = 100;
   localparam int          REC_BULB_US = 300;
   localparam int          REC_FAST_CYC = REC_FAST_US * MCLK_MHZ;
   localparam int          REC_W       = 20;

endpackage : hs_regs_pkg

// ### bench/hs_regs_properties.sv
// Concurrent checks on the pins of the high-side register bank.
`timescale 1ns/1ps
`default_nettype none
module hs_regs_properties (
   // System clock and reset.
   input wire logic       mclk,
   input wire logic       resetn,
   // Watched pins.
   input wire logic       cs_n,
   input wire logic       so_oe,
   input wire logic [3:0] oc_det,
   input wire logic       vs_uv_det,
   input wire logic [3:0] hs_gate,
   input wire logic [3:0] sense_hs_onehot,
   input wire logic       shared_sense_pwm_pin_oe,
   input wire logic       standby
);
   // Everything here lives in the system clock domain.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // Two cycles of standby allow for the registered gate stage.
   a_standby_gates_off: assert property (standby [*2] |-> hs_gate == 4'h0)
      else $error("output on in standby");
   a_standby_sense_off: assert property (standby [*2] |-> !shared_sense_pwm_pin_oe)
      else $error("sense pin driven in standby");
   a_sense_needs_pin: assert property (sense_hs_onehot != 4'h0 |-> shared_sense_pwm_pin_oe)
      else $error("sense selected but pin not driven");
   a_sense_one_stage: assert property ($onehot0(sense_hs_onehot))
      else $error("more than one stage sensed");
   // Five samples cover the two-flop synchroniser and the gate register.
   a_overcurrent_off: assert property (oc_det[3] [*5] |-> !hs_gate[0])
      else $error("output seven on during overcurrent");
   a_undervolt_off: assert property (vs_uv_det [*5] |-> hs_gate == 4'h0)
      else $error("output on during undervoltage");
   a_so_driven: assert property (!cs_n |-> so_oe)
      else $error("serial out not driven in frame");
   a_so_released: assert property (cs_n |-> !so_oe)
      else $error("serial out driven outside frame");
   c_frame: cover property ($fell(cs_n));
   c_sense: cover property ($rose(shared_sense_pwm_pin_oe));
   c_overcurrent: cover property (oc_det[3] ##1 !oc_det[3]);
endmodule : hs_regs_properties
bind hs_output_ctrl_diag_regs hs_regs_properties hs_regs_properties_i (
   .mclk(mclk), .resetn(resetn), .cs_n(cs_n), .so_oe(so_oe), .oc_det(oc_det),
   .vs_uv_det(vs_uv_det), .hs_gate(hs_gate), .sense_hs_onehot(sense_hs_onehot),
   .shared_sense_pwm_pin_oe(shared_sense_pwm_pin_oe), .standby(standby));
`default_nettype wire

// ### bench/spi_host_model.sv
// Behavioural host that runs 24-bit frames on the serial port.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   // Serial port, host side.
   output logic      sclk,
   output logic      cs_n,
   output logic      si,
   input  wire logic so_o
);
   // The link clock stands still low and select stays high between frames.
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end
   // One frame, MSB first, 30 ns link clock; the answer is gathered bit by bit.
   task automatic frame(input logic [7:0] cmd, input logic [15:0] dat,
                        output logic [23:0] rsp);
      logic [23:0] tx;
      tx = {cmd, dat};
      cs_n = 1'b0;
      #200;
      for (int i = 23; i >= 0; i--) begin
         si = tx[i];
         #15;
         rsp[i] = so_o;
         sclk = 1'b1;
         #15;
         sclk = 1'b0;
      end
      #15;
      cs_n = 1'b1;
      si = ~si;
      // The idle gap lets a write land before the next frame starts.
      #300;
   endtask : frame
endmodule : spi_host_model
`default_nettype wire

// ### bench/hs_output_ctrl_diag_regs_tb_top.sv
// Self-checking bench for the high-side control and diagnostic register bank.
`timescale 1ns/1ps
`default_nettype none
module hs_output_ctrl_diag_regs_tb_top;
   import hs_regs_pkg::*;
   logic        mclk, sclk, cs_n, si, so_o, so_oe, oe, stby;
   logic        resetn = 1'b0, vs_uv = 1'b0, ext1 = 1'b0, ext2 = 1'b0;
   logic [3:0]  ovc = 4'h0, gate, sense;
   logic [2:0]  ipwm = 3'h0;
   logic [23:0] r;
   int          fails = 0, comparisons = 0, cyc = 0;
   // The shared pin reads low while the device drives it as a sense output.
   wire logic   pin_lvl = oe ? 1'b0 : ext2;
   hs_output_ctrl_diag_regs #(.REC_SLOW_CYC(20), .REC_BULB_CYC(12)) hs_output_ctrl_diag_regs_i (
      .mclk(mclk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .si(si), .so_o(so_o),
      .so_oe(so_oe), .oc_det(ovc), .uld_det(4'h0), .vs_ov_det(1'b0), .vs_uv_det(vs_uv),
      .bulb_mode(1'b0), .external_pwm_input_one(ext1), .shared_sense_pwm_pin_i(pin_lvl),
      .internal_pwm_generator(ipwm), .hs_gate(gate), .sense_hs_onehot(sense),
      .shared_sense_pwm_pin_oe(oe), .standby(stby));
   spi_host_model spi_host_model_i (.sclk(sclk), .cs_n(cs_n), .si(si), .so_o(so_o));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic results;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results
   // A hung handshake must not stall the run forever.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 10000) begin
         fails++;
         results();
      end
   end
   task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic xf(input logic [7:0] c, input logic [15:0] d);
      spi_host_model_i.frame(c, d, r);
   endtask : xf
   task automatic settle(input int n);
      repeat (n) @(negedge mclk);
   endtask : settle
   // Overcurrent on output seven, long enough to pass the synchroniser.
   task automatic pulse;
      ovc = 4'h8;
      settle(6);
      ovc = 4'h0;
   endtask : pulse
   initial begin
      settle(8);
      resetn = 1'b1;
      settle(4);
      xf({2'b10, ADDR_CTRL1}, 16'hFFFF);
      xf({2'b00, ADDR_CTRL1}, 16'h0000);
      chk("ctrl1 standby", 24'h0, {8'h0, r[15:0]});
      xf({2'b10, ADDR_CTRL0}, 16'h0001);
      xf({2'b10, ADDR_CTRL1}, 16'hFFFF);
      xf({2'b10, ADDR_CTRL1}, 16'h3E00);
      chk("ctrl1 previous", 24'h003E00, r);
      xf({2'b10, ADDR_CTRL3}, 16'hFFFF);
      xf({2'b10, ADDR_CTRL3}, 16'h03C0);
      chk("ctrl3 previous", 24'h007BFF, r);
      // Each pwm input pair: outputs four and six follow two, five and seven one.
      for (int i = 0; i < 4; i++) begin
         ext1 = i[0];
         ext2 = i[1];
         settle(6);
         chk("gate pwm", {20'h0, i[1], i[0], i[1], i[0]}, {20'h0, gate});
      end
      ext1 = 1'b0;
      ext2 = 1'b0;
      ipwm = 3'h2;
      xf({2'b10, ADDR_PWM56}, 16'h4000);
      chk("gate internal", 24'h4, {20'h0, gate});
      xf({2'b10, ADDR_PWM56}, 16'h0000);
      for (int k = 0; k < 6; k++) begin
         xf({2'b10, ADDR_CTRL3}, 16'(k));
         chk("sense", {19'h0, k != 0, (k > 0 && k < 5) ? 4'h1 << (k - 1) : 4'h0},
             {19'h0, oe, sense});
      end
      xf({2'b10, ADDR_CTRL3}, 16'h0000);
      pulse();
      settle(40);
      chk("gate latched", 24'hE, {20'h0, gate});
      xf({2'b00, ADDR_STAT2}, 16'h0000);
      chk("status overcurrent", 24'hC00080, r);
      xf({2'b01, ADDR_STAT2}, 16'h0000);
      chk("gate cleared", 24'hF, {20'h0, gate});
      // Slow then fast recovery; the fast check at 100 cycles catches a slow pick.
      for (int j = 0; j < 2; j++) begin
         xf({2'b10, ADDR_CTRL3}, (j != 0) ? 16'h0820 : 16'h0800);
         pulse();
         settle((j != 0) ? 100 : 10);
         chk("gate recovering", 24'hE, {20'h0, gate});
         settle((j != 0) ? 2420 : 20);
         chk("gate recovered", 24'hF, {20'h0, gate});
      end
      xf({2'b01, ADDR_STAT2}, 16'h0000);
      xf({2'b10, ADDR_CTRL3}, 16'h0010);
      vs_uv = 1'b1;
      settle(6);
      vs_uv = 1'b0;
      settle(40);
      chk("gate undervoltage", 24'h0, {20'h0, gate});
      xf({2'b00, ADDR_STAT2}, 16'h0000);
      chk("status undervoltage", 24'hC00008, r);
      xf({2'b01, ADDR_STAT2}, 16'h0000);
      chk("gate cleared", 24'hF, {20'h0, gate});
      xf({2'b00, 6'h05}, 16'h0000);
      chk("unmapped", 24'h0, {8'h0, r[15:0]});
      xf({2'b10, ADDR_CTRL0}, 16'h0000);
      chk("standby gate", 24'h10, {19'h0, stby, gate});
      xf({2'b00, ADDR_CTRL1}, 16'h0000);
      chk("ctrl1 cleared", 24'h0, {8'h0, r[15:0]});
      results();
   end
endmodule : hs_output_ctrl_diag_regs_tb_top
`default_nettype wire
